// *** drive_di_map.vh ***
`ifndef DRIVE_DI_MAP_VH
`define DRIVE_DI_MAP_VH
// ****************************************
// Register offsets
// ****************************************
`define OFS_CTRL        8'h00
`define OFS_FSEL_LO     8'h04
`define OFS_FSEL_HI     8'h08
`define OFS_UPPER       8'h0C
`define OFS_LOWER       8'h10
`define OFS_JOG         8'h14
`define OFS_STATUS      8'h18
`define OFS_FREQ        8'h1C
// ****************************************
// Control fields
// ****************************************
`define CTRL_REV_PROHIBIT 0
`define CTRL_PID_MODE     1
`define CTRL_LIMSRC       3:2
`define CTRL_STOP         5:4
`define CTRL_OL           7:6
`define CTRL_W            8
// ****************************************
// Status fields
// ****************************************
`define ST_FAULT        0
`define ST_EXT_ALARM    1
`define ST_CONFLICT     2
`define ST_RUN_ALARM    3
`define ST_LOCK         4
`define ST_FS_BLOCK     5
`define ST_MOTOR2       6
`define ST_PID          7
`define ST_FTERM        10:8
`define ST_JOG_FAULT    11
// ****************************************
// Reset values
// ****************************************
`define RST_CTRL        8'h00
`define RST_FSEL        64'h0000_0000_0000_0000
`define RST_UPPER       16'hFFFF
`define RST_LOWER       16'h0000
`define RST_JOG         16'h0000
// ****************************************
// Input function codes
// ****************************************
`define FN_ACC1         8'h07
`define FN_HOLD         8'h0A
`define FN_UP           8'h10
`define FN_DOWN         8'h11
`define FN_FORWARD_JOG_INPUT         8'h12
`define FN_REVERSE_JOG_INPUT         8'h13
`define FN_RESET        8'h14
`define FN_FS_NO        8'h15
`define FN_MOTOR2       8'h16
`define FN_FS_NC        8'h17
`define FN_PID_CANCEL   8'h19
`define FN_ACC2         8'h1A
`define FN_LOCK         8'h1B
`define FN_SH           8'h1E
`define FN_EXT_HI       4'h2
`define FN_OFS1         8'h44
`define FN_OFS3         8'h46
`define FN_UD2_UP       8'h75
`define FN_UD2_DN       8'h76
`define EF_NC           0
`define EF_RUN_ONLY     1
`define EF_MODE         3:2
`define EF_ALARM        2'b11
`define EF_COAST        2'b01
// ****************************************
// Limit sources
// ****************************************
`define LIM_PARAM       2'b00
`define LIM_ANALOG      2'b01
// ****************************************
// Timing
// ****************************************
`define CLK_HZ          10000000
`define MS_CYCLES_DEF   (`CLK_HZ / 1000)
`define JOG_CONFLICT_MS 500
`define SH_HOLD_MS      100
`endif

// *** drive_digital_input_functions.v ***
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "drive_di_map.vh"
module drive_digital_input_functions #(
  parameter NUM_TERM  = 7,
  parameter MS_CYCLES = `MS_CYCLES_DEF,
  parameter UD_STEP   = 16'h0001
) (
  input  wire                pclk,
  input  wire                presetn,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [7:0]          paddr,
  input  wire [31:0]         pwdata,
  output reg  [31:0]         prdata,
  output reg                 pready,
  output reg                 pslverr,
  input  wire [NUM_TERM-1:0] term_in,
  input  wire                run_cmd,
  input  wire                reset_key,
  input  wire                motor_stopped,
  input  wire                fault_det,
  input  wire [15:0]         analog_ref,
  input  wire [15:0]         analog_lower,
  output reg  [15:0]         freq_ref,
  output reg                 reverse_dir,
  output reg                 run_out,
  output reg                 fault_contact,
  output reg                 output_off,
  output reg  [1:0]          fault_stop_mode,
  output reg                 decel_fast,
  output reg  [1:0]          accel_set,
  output reg                 motor2_out,
  output reg  [1:0]          overload_protect_select,
  output reg                 pid_enable,
  output reg                 param_lock,
  output reg                 external_fault_indication,
  output reg  [2:0]          fault_terminal
);
  // ****************************************
  // Decode helpers
  // ****************************************
  function match;
    input [7:0] fn;
    input [7:0] code;
    begin
      match = (fn == code);
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  reg  [`CTRL_W-1:0] ctrl;
  reg  [63:0]        input_function_select;
  reg  [15:0]        ref_upper_limit;
  reg  [15:0]        ref_lower_limit;
  reg  [15:0]        jog_reference;
  reg  [15:0]        ud_ref;
  reg  [15:0]        sh_ref;
  reg                fault;
  reg                jog_fault;
  reg                ext_alarm;
  reg                run_alarm;
  reg                fs_block;
  reg                motor2;
  reg                conflict;
  reg  [13:0]        ms_cnt;
  reg                ms_tick;
  reg  [9:0]         jog_ms;
  reg  [6:0]         sh_ms;
  reg                sh_done;

  // ****************************************
  // Per-terminal decode
  // ****************************************
  wire [NUM_TERM-1:0] h_up, h_dn, h_fj, h_rj, h_rst, h_fs, h_m2, h_pc;
  wire [NUM_TERM-1:0] h_a1, h_a2, h_lk, h_sh, ef_flt, ef_alm;
  wire [NUM_TERM-1:0] a_up, a_dn, a_lk, a_sh, a_other;
  wire                run_active;

  genvar t;
  generate
    for (t = 0; t < NUM_TERM; t = t + 1) begin : g_term
      wire [7:0] f   = input_function_select[8*t +: 8];
      wire       i   = term_in[t];
      wire       ef  = (f[7:4] == `FN_EXT_HI);
      wire       lvl = f[`EF_NC] ? ~i : i;
      wire       det = ef & lvl & (~f[`EF_RUN_ONLY] | run_active);
      assign a_up[t]   = match(f, `FN_UP);
      assign a_dn[t]   = match(f, `FN_DOWN);
      assign a_lk[t]   = match(f, `FN_LOCK);
      assign a_sh[t]   = match(f, `FN_SH);
      assign a_other[t] = match(f, `FN_HOLD) | a_up[t] | a_dn[t] |
                          (f >= `FN_OFS1 && f <= `FN_OFS3) |
                          match(f, `FN_UD2_UP) | match(f, `FN_UD2_DN);
      assign h_up[t]  = a_up[t] & i;
      assign h_dn[t]  = a_dn[t] & i;
      assign h_fj[t]  = match(f, `FN_FORWARD_JOG_INPUT) & i;
      assign h_rj[t]  = match(f, `FN_REVERSE_JOG_INPUT) & i;
      assign h_rst[t] = match(f, `FN_RESET) & i;
      assign h_fs[t]  = (match(f, `FN_FS_NO) & i) | (match(f, `FN_FS_NC) & ~i);
      assign h_m2[t]  = match(f, `FN_MOTOR2) & i;
      assign h_pc[t]  = match(f, `FN_PID_CANCEL) & i;
      assign h_a1[t]  = match(f, `FN_ACC1) & i;
      assign h_a2[t]  = match(f, `FN_ACC2) & i;
      assign h_lk[t]  = a_lk[t] & ~i;
      assign h_sh[t]  = a_sh[t] & i;
      assign ef_flt[t] = det & (f[`EF_MODE] != `EF_ALARM);
      assign ef_alm[t] = det & (f[`EF_MODE] == `EF_ALARM);
    end
  endgenerate

  wire up      = |h_up;
  wire dn      = |h_dn;
  wire forward_jog_input    = |h_fj;
  wire reverse_jog_input_in = |h_rj;
  wire reverse_jog_input    = reverse_jog_input_in & ~ctrl[`CTRL_REV_PROHIBIT];
  wire jog     = forward_jog_input | reverse_jog_input;
  wire fs_hit  = |h_fs;
  wire lock    = |h_lk;
  assign run_active = (run_cmd & ~fault & ~fs_block) | (jog & ~fault);

  // ****************************************
  // Millisecond tick
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt  <= 14'h0000;
      ms_tick <= 1'b0;
    end else if (ms_cnt == MS_CYCLES[13:0] - 14'h0001) begin
      ms_cnt  <= 14'h0000;
      ms_tick <= 1'b1;
    end else begin
      ms_cnt  <= ms_cnt + 14'h0001;
      ms_tick <= 1'b0;
    end
  end

  // ****************************************
  // Qualification counters
  // ****************************************
  wire jog_conf_hit = (jog_ms == `JOG_CONFLICT_MS - 1) & ms_tick & forward_jog_input & reverse_jog_input_in;
  wire sh_hit       = (sh_ms == `SH_HOLD_MS - 1) & ms_tick & (|h_sh) & ~sh_done;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jog_ms  <= 10'h000;
      sh_ms   <= 7'h00;
      sh_done <= 1'b0;
      sh_ref  <= 16'h0000;
    end else begin
      if (!(forward_jog_input & reverse_jog_input_in))
        jog_ms <= 10'h000;
      else if (ms_tick && jog_ms != `JOG_CONFLICT_MS - 1)
        jog_ms <= jog_ms + 10'h001;
      if (!(|h_sh)) begin
        sh_ms   <= 7'h00;
        sh_done <= 1'b0;
      end else if (ms_tick && sh_ms != `SH_HOLD_MS - 1) begin
        sh_ms <= sh_ms + 7'h01;
      end
      if (sh_hit) begin
        sh_ref  <= analog_ref;
        sh_done <= 1'b1;
      end
    end
  end

  // ****************************************
  // Fault handling
  // ****************************************
  reg       ef_any;
  reg [2:0] ef_term;
  reg [1:0] ef_mode;
  integer   k;
  always @* begin
    ef_any  = 1'b0;
    ef_term = 3'b000;
    ef_mode = 2'b00;
    for (k = NUM_TERM - 1; k >= 0; k = k - 1) begin
      if (ef_flt[k]) begin
        ef_any  = 1'b1;
        ef_term = k[2:0];
        ef_mode = input_function_select[8*k+2 +: 2];
      end
    end
  end

  wire reset_req = (|h_rst | reset_key) & ~run_cmd;
  wire new_fault = ef_any | jog_conf_hit | fault_det;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault           <= 1'b0;
      jog_fault       <= 1'b0;
      ext_alarm       <= 1'b0;
      fault_terminal  <= 3'b000;
      fault_stop_mode <= 2'b00;
    end else begin
      ext_alarm <= |ef_alm;
      if (new_fault && !fault) begin
        fault     <= 1'b1;
        jog_fault <= jog_conf_hit;
        if (fault_det)
          fault_stop_mode <= `EF_COAST;
        else if (ef_any) begin
          fault_stop_mode <= ef_mode;
          fault_terminal  <= ef_term;
        end else
          fault_stop_mode <= ctrl[`CTRL_STOP];
      end else if (reset_req && !new_fault) begin
        fault     <= 1'b0;
        jog_fault <= 1'b0;
      end
    end
  end

  // ****************************************
  // Fast-stop and motor select
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_block  <= 1'b0;
      motor2    <= 1'b0;
      run_alarm <= 1'b0;
    end else begin
      if (fs_hit && (run_cmd || jog))
        fs_block <= 1'b1;
      else if (motor_stopped && !fs_hit && !run_cmd)
        fs_block <= 1'b0;
      if (!run_active)
        motor2 <= |h_m2;
      run_alarm <= run_active & ((|h_m2) != motor2);
    end
  end

  // ****************************************
  // Up/down reference
  // ****************************************
  reg [15:0] next_ud;
  reg [15:0] lo;
  always @* begin
    next_ud = ud_ref;
    if (ms_tick && up && !dn)
      next_ud = (ud_ref > 16'hFFFF - UD_STEP) ? 16'hFFFF : ud_ref + UD_STEP;
    else if (ms_tick && dn && !up)
      next_ud = (ud_ref < UD_STEP) ? 16'h0000 : ud_ref - UD_STEP;
    case (ctrl[`CTRL_LIMSRC])
      `LIM_PARAM:  lo = ref_lower_limit;
      `LIM_ANALOG: lo = (up | dn) ? analog_lower : 16'h0000;
      default:     lo = ((up | dn) && analog_lower > ref_lower_limit) ?
                        analog_lower : ref_lower_limit;
    endcase
    if (next_ud < lo && (lo == ref_lower_limit || up || dn))
      next_ud = lo;
    if (next_ud > ref_upper_limit)
      next_ud = ref_upper_limit;
    if (!run_cmd)
      next_ud = 16'h0000;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ud_ref <= 16'h0000;
    else
      ud_ref <= next_ud;
  end

  // ****************************************
  // Configuration check
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      conflict <= 1'b0;
    else
      conflict <= ((|a_sh) & (|a_other)) | ((|a_up) ^ (|a_dn));
  end

  // ****************************************
  // Command outputs
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_ref                  <= 16'h0000;
      reverse_dir               <= 1'b0;
      run_out                   <= 1'b0;
      fault_contact             <= 1'b0;
      output_off                <= 1'b0;
      decel_fast                <= 1'b0;
      accel_set                 <= 2'b00;
      motor2_out                <= 1'b0;
      overload_protect_select   <= 2'b00;
      pid_enable                <= 1'b0;
      param_lock                <= 1'b0;
      external_fault_indication <= 1'b0;
    end else begin
      if (jog && !fault) begin
        freq_ref    <= jog_reference;
        reverse_dir <= reverse_jog_input & ~forward_jog_input;
      end else begin
        freq_ref    <= (|a_sh) ? sh_ref : ud_ref;
        reverse_dir <= 1'b0;
      end
      run_out       <= run_active & ~(fault_stop_mode == `EF_COAST && fault);
      fault_contact <= fault;
      output_off    <= fault & (fault_stop_mode == `EF_COAST);
      decel_fast    <= fs_block;
      accel_set     <= motor2 ? {1'b1, |h_a1} : {|h_a2, |h_a1};
      motor2_out    <= motor2;
      overload_protect_select <= ctrl[`CTRL_OL];
      pid_enable    <= ctrl[`CTRL_PID_MODE] & ~(|h_pc);
      param_lock    <= lock;
      external_fault_indication <= fault & ~jog_fault & ~fault_det;
    end
  end

  // ****************************************
  // APB slave, one wait state
  // ****************************************
  wire       acc   = psel & penable & pready;
  wire       wr    = acc & pwrite;
  wire [31:0] status = {20'h0_0000, jog_fault, fault_terminal, pid_enable,
                        motor2, fs_block, lock, run_alarm, conflict,
                        ext_alarm, fault};
  wire       known = (paddr == `OFS_CTRL) | (paddr == `OFS_FSEL_LO) |
                     (paddr == `OFS_FSEL_HI) | (paddr == `OFS_UPPER) |
                     (paddr == `OFS_LOWER) | (paddr == `OFS_JOG) |
                     (paddr == `OFS_STATUS) | (paddr == `OFS_FREQ);
  wire       wr_ok = wr & ~lock;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready                <= 1'b0;
      pslverr               <= 1'b0;
      prdata                <= 32'h0000_0000;
      ctrl                  <= `RST_CTRL;
      input_function_select <= `RST_FSEL;
      ref_upper_limit       <= `RST_UPPER;
      ref_lower_limit       <= `RST_LOWER;
      jog_reference         <= `RST_JOG;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & (~known | (pwrite & lock));
      if (psel && penable && !pready && !pwrite) begin
        case (paddr)
          `OFS_CTRL:    prdata <= {24'h00_0000, ctrl};
          `OFS_FSEL_LO: prdata <= input_function_select[31:0];
          `OFS_FSEL_HI: prdata <= input_function_select[63:32];
          `OFS_UPPER:   prdata <= {16'h0000, ref_upper_limit};
          `OFS_LOWER:   prdata <= {16'h0000, ref_lower_limit};
          `OFS_JOG:     prdata <= {16'h0000, jog_reference};
          `OFS_STATUS:  prdata <= status;
          `OFS_FREQ:    prdata <= {16'h0000, freq_ref};
          default:      prdata <= 32'h0000_0000;
        endcase
      end
      if (wr_ok) begin
        case (paddr)
          `OFS_CTRL:    ctrl <= pwdata[`CTRL_W-1:0];
          `OFS_FSEL_LO: input_function_select[31:0] <= pwdata;
          `OFS_FSEL_HI: input_function_select[63:32] <= pwdata;
          `OFS_UPPER:   ref_upper_limit <= pwdata[15:0];
          `OFS_LOWER:   ref_lower_limit <= pwdata[15:0];
          `OFS_JOG:     jog_reference <= pwdata[15:0];
          default:      ctrl <= ctrl;
        endcase
      end
    end
  end
endmodule

// *** drive_di_monitor.sv ***
`timescale 1ns/100ps
module drive_di_monitor (
  input wire       pclk,
  input wire       presetn,
  input wire       psel,
  input wire       penable,
  input wire       pready,
  input wire       pslverr,
  input wire       run_cmd,
  input wire       motor_stopped,
  input wire       fault_det,
  input wire       run_out,
  input wire       fault_contact,
  input wire       output_off,
  input wire       decel_fast,
  input wire [1:0] accel_set,
  input wire       motor2_out,
  input wire [1:0] overload_protect_select
);
  // ****************************************
  // Port checks
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_fault_coast: assert property (fault_det |-> ##2 (fault_contact && output_off))
    else $error("fault source not latched");
  a_off_fault: assert property (output_off |-> fault_contact)
    else $error("output off without fault");
  a_reset_run: assert property (fault_contact && run_cmd && $past(run_cmd) |=> fault_contact)
    else $error("fault cleared during run");
  a_clear_cause: assert property ($fell(fault_contact) |-> !$past(run_cmd, 2))
    else $error("fault cleared after run");
  a_restart_block: assert property (decel_fast && ($past(run_cmd) || !$past(motor_stopped)) |=> decel_fast)
    else $error("fast stop block released early");
  a_motor_run: assert property (run_out |=> $stable(motor2_out))
    else $error("motor changed while running");
  a_motor_sets: assert property (motor2_out && $past(motor2_out) |-> accel_set[1])
    else $error("motor 2 accel set wrong");
  a_ovl_shared: assert property ($changed(motor2_out) |-> $stable(overload_protect_select))
    else $error("overload select follows motor");
  c_fault: cover property ($rose(fault_contact));
  c_fast: cover property ($rose(decel_fast));
  c_motor2: cover property ($rose(motor2_out));
endmodule
bind drive_digital_input_functions drive_di_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .run_cmd(run_cmd), .motor_stopped(motor_stopped), .fault_det(fault_det),
  .run_out(run_out), .fault_contact(fault_contact), .output_off(output_off),
  .decel_fast(decel_fast), .accel_set(accel_set), .motor2_out(motor2_out),
  .overload_protect_select(overload_protect_select)
);

// *** plc_contacts.sv ***
`timescale 1ns/100ps
module plc_contacts (
  input  wire        pclk,
  input  wire [6:0]  want_closed,
  input  wire        want_run,
  input  wire        want_key,
  input  wire        want_stopped,
  input  wire        want_fault,
  input  wire [15:0] want_ref,
  input  wire [15:0] want_low,
  output reg  [6:0]  term_in,
  output reg         run_cmd,
  output reg         reset_key,
  output reg         motor_stopped,
  output reg         fault_det,
  output reg  [15:0] analog_ref,
  output reg  [15:0] analog_lower
);
  // ****************************************
  // Contacts and sensors
  // ****************************************
  initial begin
    {term_in, run_cmd, reset_key, motor_stopped, fault_det} = 11'h000;
    {analog_ref, analog_lower} = 32'h0000_0000;
  end
  always @(posedge pclk) begin
    term_in       <= want_closed;
    run_cmd       <= want_run;
    reset_key     <= want_key;
    motor_stopped <= want_stopped;
    fault_det     <= want_fault;
    analog_ref    <= want_ref;
    analog_lower  <= want_low;
  end
endmodule

// *** drive_digital_input_functions_tb.sv ***
`timescale 1ns/100ps
`include "drive_di_map.vh"
`define CHK(n, e, g) begin \
  cmp_count = cmp_count + 1; \
  if ((g) !== (e)) begin \
    err_total = err_total + 1; \
    $display("wrong value %s expected %h seen %h", n, e, g); \
  end \
end
module drive_digital_input_functions_tb;
  // ****************************************
  // Signals
  // ****************************************
  localparam [6:0]  LK  = 7'h20;
  localparam [47:0] EFC = 48'h2021_2224_282C;
  localparam [55:0] CFC = 56'h0A_1044_4546_7576;
  reg         pclk, presetn, psel, penable, pwrite, run, key, stp, fdet, rerr, ex;
  reg  [7:0]  paddr, code;
  reg  [15:0] aref, alow;
  reg  [31:0] pwdata, rdat;
  reg  [6:0]  closed;
  integer     err_total, cmp_count, cyc, i;
  wire        pready, pslverr, run_cmd, reset_key, motor_stopped, fault_det, reverse_dir, run_out;
  wire        fault_contact, output_off, decel_fast, motor2_out, external_fault_indication;
  wire        pid_enable, param_lock;
  wire [1:0]  fault_stop_mode, accel_set, overload_protect_select;
  wire [2:0]  fault_terminal;
  wire [6:0]  term_in;
  wire [15:0] analog_ref, analog_lower, freq_ref;
  wire [31:0] prdata;
  plc_contacts far (
    .pclk(pclk), .want_closed(closed), .want_run(run), .want_key(key), .want_stopped(stp),
    .want_fault(fdet), .want_ref(aref), .want_low(alow), .term_in(term_in), .run_cmd(run_cmd),
    .reset_key(reset_key), .motor_stopped(motor_stopped), .fault_det(fault_det),
    .analog_ref(analog_ref), .analog_lower(analog_lower)
  );
  drive_digital_input_functions #(.NUM_TERM(7), .MS_CYCLES(10), .UD_STEP(16'h0001)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .term_in(term_in), .run_cmd(run_cmd), .reset_key(reset_key), .motor_stopped(motor_stopped),
    .fault_det(fault_det), .analog_ref(analog_ref), .analog_lower(analog_lower),
    .freq_ref(freq_ref), .reverse_dir(reverse_dir), .run_out(run_out),
    .fault_contact(fault_contact), .output_off(output_off), .fault_stop_mode(fault_stop_mode),
    .decel_fast(decel_fast), .accel_set(accel_set), .motor2_out(motor2_out),
    .overload_protect_select(overload_protect_select), .pid_enable(pid_enable), .param_lock(param_lock),
    .external_fault_indication(external_fault_indication), .fault_terminal(fault_terminal)
  );
  // ****************************************
  // Clock, tasks and timeout
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task tk(input integer n);
    begin
      repeat (n) @(posedge pclk);
      #1;
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
        @(posedge pclk);
        n = n + 1;
      end
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) err_total = err_total + 1;
      #1;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task st;
    apb(1'b0, `OFS_STATUS, 32'h0);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      `CHK("rdata", e, rdat)
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      tally_and_finish;
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {presetn, psel, penable, pwrite, run, key, fdet, rerr, ex} = 9'h000;
    {paddr, code, pwdata, rdat, aref} = 96'h0;
    {err_total, cmp_count, cyc} = 96'h0;
    closed = 7'h00;
    stp = 1'b1;
    alow = 16'h0004;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFS_CTRL, 32'h0);
    rd(`OFS_UPPER, 32'h0000_FFFF);
    rd(`OFS_LOWER, 32'h0);
    rd(`OFS_JOG, 32'h0);
    rd(8'h20, 32'h0);
    `CHK("unmapped", 1'b1, rerr)
    for (i = 0; i < 7; i = i + 1) begin
      wr(`OFS_FSEL_LO, {16'h0000, CFC[55-8*i -: 8], 8'h1E});
      st;
      `CHK("conflict", 1'b1, rdat[`ST_CONFLICT])
    end
    closed = LK;
    wr(`OFS_FSEL_HI, 32'h0000_1B16);
    wr(`OFS_FSEL_LO, 32'h1514_1312);
    wr(`OFS_JOG, 32'h0000_0123);
    st;
    `CHK("conflict", 1'b0, rdat[`ST_CONFLICT])
    closed = LK | 7'h01;
    tk(3);
    `CHK("freq", 16'h0123, freq_ref)
    `CHK("rev", 1'b0, reverse_dir)
    `CHK("run", 1'b1, run_out)
    closed = LK | 7'h02;
    tk(3);
    `CHK("rev", 1'b1, reverse_dir)
    wr(`OFS_CTRL, 32'h1);
    tk(3);
    `CHK("run", 1'b0, run_out)
    closed = LK;
    wr(`OFS_CTRL, 32'h20);
    closed = LK | 7'h03;
    tk(4800);
    `CHK("fault", 1'b0, fault_contact)
    tk(400);
    `CHK("fault", 1'b1, fault_contact)
    `CHK("mode", 2'd2, fault_stop_mode)
    st;
    `CHK("jogflt", 1'b1, rdat[`ST_JOG_FAULT])
    closed = LK | 7'h04;
    tk(3);
    `CHK("fault", 1'b0, fault_contact)
    closed = LK;
    fdet = 1'b1;
    tk(3);
    `CHK("off", 1'b1, output_off)
    fdet = 1'b0;
    run = 1'b1;
    closed = LK | 7'h04;
    key = 1'b1;
    tk(4);
    `CHK("fault", 1'b1, fault_contact)
    run = 1'b0;
    tk(4);
    `CHK("fault", 1'b0, fault_contact)
    key = 1'b0;
    for (i = 0; i < 6; i = i + 1) begin
      code = EFC[47-8*i -: 8];
      ex = (code[1:0] == 2'b00) && (code[3:2] != `EF_ALARM);
      closed = LK | 7'h40;
      wr(`OFS_FSEL_HI, {8'h00, code, 16'h1B16});
      tk(3);
      `CHK("fault", ex, fault_contact)
      if (ex) begin
        `CHK("mode", code[3:2], fault_stop_mode)
        `CHK("off", code[3:2] == `EF_COAST, output_off)
        `CHK("ext", 1'b1, external_fault_indication)
        `CHK("term", 3'd6, fault_terminal)
      end
      if (code == 8'h2C) begin
        st;
        `CHK("alarm", 1'b1, rdat[`ST_EXT_ALARM])
      end
      wr(`OFS_FSEL_HI, 32'h0000_1B16);
      closed = LK | 7'h04;
      tk(3);
    end
    closed = LK;
    stp = 1'b0;
    run = 1'b1;
    tk(3);
    closed = LK | 7'h08;
    tk(3);
    `CHK("fast", 1'b1, decel_fast)
    closed = LK;
    tk(3);
    `CHK("fast", 1'b1, decel_fast)
    run = 1'b0;
    tk(3);
    `CHK("fast", 1'b1, decel_fast)
    stp = 1'b1;
    tk(3);
    `CHK("fast", 1'b0, decel_fast)
    closed = LK | 7'h08;
    wr(`OFS_FSEL_LO, 32'h1714_1312);
    run = 1'b1;
    tk(3);
    `CHK("fast", 1'b0, decel_fast)
    closed = LK;
    tk(3);
    `CHK("fast", 1'b1, decel_fast)
    run = 1'b0;
    wr(`OFS_FSEL_LO, 32'h1514_1312);
    wr(`OFS_CTRL, 32'hC0);
    closed = LK | 7'h10;
    tk(3);
    `CHK("motor2", 1'b1, motor2_out)
    `CHK("accel", 1'b1, accel_set[1])
    `CHK("ovl", 2'b11, overload_protect_select)
    run = 1'b1;
    tk(3);
    closed = LK;
    tk(3);
    `CHK("motor2", 1'b1, motor2_out)
    st;
    `CHK("runalm", 1'b1, rdat[`ST_RUN_ALARM])
    run = 1'b0;
    tk(3);
    `CHK("motor2", 1'b0, motor2_out)
    closed = 7'h00;
    tk(3);
    `CHK("lock", 1'b1, param_lock)
    wr(`OFS_UPPER, 32'h5);
    `CHK("lockerr", 1'b1, rerr)
    rd(`OFS_UPPER, 32'h0000_FFFF);
    closed = LK;
    wr(`OFS_FSEL_LO, 32'h1514_1110);
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_UPPER, 32'h5);
    wr(`OFS_LOWER, 32'h3);
    run = 1'b1;
    tk(30);
    `CHK("freq", 16'h0003, freq_ref)
    closed = LK | 7'h01;
    tk(60);
    `CHK("freq", 16'h0005, freq_ref)
    closed = LK | 7'h03;
    tk(30);
    `CHK("freq", 16'h0005, freq_ref)
    closed = LK | 7'h02;
    tk(60);
    `CHK("freq", 16'h0003, freq_ref)
    run = 1'b0;
    closed = LK;
    wr(`OFS_CTRL, 32'h8);
    run = 1'b1;
    tk(30);
    `CHK("freq", 16'h0003, freq_ref)
    run = 1'b0;
    wr(`OFS_CTRL, 32'h4);
    run = 1'b1;
    tk(30);
    `CHK("freq", 16'h0000, freq_ref)
    closed = LK | 7'h01;
    tk(30);
    `CHK("freq", 1'b1, freq_ref >= 16'h0004)
    run = 1'b0;
    closed = LK;
    wr(`OFS_FSEL_LO, 32'h1514_121E);
    aref = 16'h0456;
    closed = LK | 7'h01;
    tk(900);
    `CHK("freq", 16'h0000, freq_ref)
    tk(200);
    `CHK("freq", 16'h0456, freq_ref)
    closed = LK | 7'h03;
    tk(3);
    `CHK("freq", 16'h0123, freq_ref)
    wr(`OFS_FSEL_HI, 32'h0019_1B16);
    wr(`OFS_CTRL, 32'h2);
    closed = LK;
    tk(3);
    `CHK("pid", 1'b1, pid_enable)
    `CHK("lock", 1'b0, param_lock)
    closed = LK | 7'h40;
    tk(3);
    `CHK("pid", 1'b0, pid_enable)
    wr(`OFS_FSEL_HI, 32'h001A_1B16);
    tk(3);
    `CHK("accel", 2'b10, accel_set)
    tally_and_finish;
  end
endmodule
